/* rtl/wct_top.sv */
// wct_top: wake-up compare timer with its two-wire serial slave
// assumes: scl, sda and hold_reset_n are asynchronous pins; clk_sys fast enough to oversample scl
`timescale 1ns/1ns
module wct_top
   import wct_pkg::*;
#(
   parameter bit ONE_SHOT  = 1'b0,
   parameter bit PUSH_PULL = 1'b0,
   parameter int OSC_HZ    = `WCT_OSC_HZ,
   parameter int PULSE_CYC = `WCT_PULSE_CYC
)(
   // system clock and reset
   input  wire logic clk_sys,
   input  wire logic rstn,
   // oscillator clock
   input  wire logic clk_osc,
   // serial bus, sda open drain
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe,
   // hold pin and interrupt pin
   input  wire logic hold_reset_n,
   output logic      wake_irq_o,
   output logic      wake_irq_oe
);
   wct_core_if xif ();

   wct_i2c_t r_ff;
   wct_i2c_t nxt_r;
   logic     scl_rise;
   logic     scl_fall;
   logic     start_c;
   logic     stop_c;
   logic [7:0] rx_byte;

   // byte of a 3-byte register, most significant first, fill past the end
   function automatic logic [7:0] byte_sel(input logic [`WCT_CNT_W-1:0] val, input logic [2:0] idx);
      logic [7:0] b;
      b = `WCT_RD_FILL;
      unique case (idx)
         3'h0: b = val[23:16];
         3'h1: b = val[15:8];
         3'h2: b = val[7:0];
         default: b = `WCT_RD_FILL;
      endcase
      return b;
   endfunction

   // serial slave and crossing, all in one next-state block
   always_comb
   begin
      nxt_r         = r_ff;
      nxt_r.scl_s1  = scl_i;
      nxt_r.scl_s2  = r_ff.scl_s1;
      nxt_r.scl_q   = r_ff.scl_s2;
      nxt_r.sda_s1  = sda_i;
      nxt_r.sda_s2  = r_ff.sda_s1;
      nxt_r.sda_q   = r_ff.sda_s2;
      nxt_r.hr_s1   = hold_reset_n;
      nxt_r.hr_s2   = r_ff.hr_s1;
      nxt_r.snap_s1 = xif.snap_tgl;
      nxt_r.snap_s2 = r_ff.snap_s1;
      scl_rise = r_ff.scl_s2 & ~r_ff.scl_q;
      scl_fall = ~r_ff.scl_s2 & r_ff.scl_q;
      // start and stop are sda edges while scl stays high
      start_c  = r_ff.scl_s2 & r_ff.scl_q & r_ff.sda_q & ~r_ff.sda_s2;
      stop_c   = r_ff.scl_s2 & r_ff.scl_q & ~r_ff.sda_q & r_ff.sda_s2;
      rx_byte  = {r_ff.shreg[6:0], r_ff.sda_s2};
      // take a snapshot of count and wake-up time when a new one is offered
      if (r_ff.snap_s2 != r_ff.ack_tgl)
      begin
         nxt_r.cnt_cp  = xif.cnt_snap;
         nxt_r.wu_cp   = xif.wu_snap;
         nxt_r.ack_tgl = r_ff.snap_s2;
      end
      if (start_c)
      begin
         nxt_r.st     = I_ADDR;
         nxt_r.bitcnt = 3'h0;
         nxt_r.oe     = 1'b0;
      end
      else if (stop_c)
      begin
         nxt_r.st  = I_IDLE;
         nxt_r.ptr = `WCT_PTR_RST;                                        // stop forgets the dummy write
         nxt_r.oe  = 1'b0;
      end
      else
      begin
         unique case (r_ff.st)
            I_IDLE: ;
            // address byte, matched against the fixed slave address
            I_ADDR:
               if (scl_rise)
               begin
                  nxt_r.shreg  = rx_byte;
                  nxt_r.bitcnt = r_ff.bitcnt + 1'b1;
                  if (r_ff.bitcnt == 3'h7)
                  begin
                     nxt_r.rw = rx_byte[0];
                     nxt_r.st = (rx_byte[7:1] == `WCT_SLV_ADDR) ? I_AACK : I_IDLE;
                  end
               end
            // acknowledge the address, then start writing or sending
            I_AACK:
               if (scl_fall)
               begin
                  if (!r_ff.oe)
                     nxt_r.oe = 1'b1;
                  else
                  begin
                     nxt_r.bitcnt = 3'h0;
                     nxt_r.bidx   = 3'h0;
                     if (r_ff.rw)
                     begin
                        // pointer low selects the wake-up time, but only with the hold pin high
                        nxt_r.rd_buf = (!r_ff.ptr && r_ff.hr_s2) ? r_ff.wu_cp : r_ff.cnt_cp;
                        nxt_r.shreg  = byte_sel(nxt_r.rd_buf, 3'h0);
                        nxt_r.oe     = ~nxt_r.shreg[7];
                        nxt_r.st     = I_RD;
                     end
                     else
                     begin
                        nxt_r.oe = 1'b0;
                        nxt_r.st = I_WR;
                     end
                  end
               end
            // pointer byte then three wake-up time bytes
            I_WR:
               if (scl_rise)
               begin
                  nxt_r.shreg  = rx_byte;
                  nxt_r.bitcnt = r_ff.bitcnt + 1'b1;
                  if (r_ff.bitcnt == 3'h7)
                  begin
                     nxt_r.st = I_WACK;
                     if (r_ff.bidx == 3'h0)
                        nxt_r.ptr = rx_byte[`WCT_PTR_BIT];
                     else if (r_ff.bidx <= `WCT_WU_BYTES)
                        nxt_r.wu_buf = {r_ff.wu_buf[15:0], rx_byte};
                     // the third data byte hands the whole value over at once
                     if (r_ff.bidx == `WCT_WU_BYTES)
                        nxt_r.req_tgl = ~r_ff.req_tgl;
                     if (r_ff.bidx != 3'h7)
                        nxt_r.bidx = r_ff.bidx + 1'b1;
                  end
               end
            I_WACK:
               if (scl_fall)
               begin
                  if (!r_ff.oe)
                     nxt_r.oe = 1'b1;
                  else
                  begin
                     nxt_r.oe     = 1'b0;
                     nxt_r.bitcnt = 3'h0;
                     nxt_r.st     = I_WR;
                  end
               end
            // shift a byte out, sda released after its last bit
            I_RD:
               if (scl_fall)
               begin
                  if (r_ff.bitcnt == 3'h7)
                  begin
                     nxt_r.oe = 1'b0;
                     nxt_r.st = I_RACK;
                  end
                  else
                  begin
                     nxt_r.bitcnt = r_ff.bitcnt + 1'b1;
                     nxt_r.shreg  = {r_ff.shreg[6:0], 1'b1};
                     nxt_r.oe     = ~r_ff.shreg[6];
                  end
               end
            // master acknowledge: low continues, high ends the read
            I_RACK:
               if (scl_rise)
                  nxt_r.st = r_ff.sda_s2 ? I_IDLE : I_RNXT;
            I_RNXT:
               if (scl_fall)
               begin
                  nxt_r.bidx   = (r_ff.bidx == 3'h7) ? r_ff.bidx : r_ff.bidx + 1'b1;
                  nxt_r.shreg  = byte_sel(r_ff.rd_buf, nxt_r.bidx);
                  nxt_r.oe     = ~nxt_r.shreg[7];
                  nxt_r.bitcnt = 3'h0;
                  nxt_r.st     = I_RD;
               end
         endcase
      end
      // synchronous reset; synchronisers keep sampling
      if (!rstn)
      begin
         nxt_r         = '0;
         nxt_r.st      = I_IDLE;
         nxt_r.ptr     = `WCT_PTR_RST;
         nxt_r.scl_s1  = scl_i;
         nxt_r.scl_s2  = r_ff.scl_s1;
         nxt_r.sda_s1  = sda_i;
         nxt_r.sda_s2  = r_ff.sda_s1;
         nxt_r.hr_s1   = hold_reset_n;
         nxt_r.hr_s2   = r_ff.hr_s1;
         nxt_r.snap_s1 = xif.snap_tgl;
         nxt_r.snap_s2 = r_ff.snap_s1;
         // start from the core's reset value: copying the synchroniser would carry
         // an undefined toggle through reset and stall the snapshot handshake
         nxt_r.ack_tgl = 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      r_ff <= nxt_r;
   end

   // open drain: only ever pull low
   assign sda_o        = 1'b0;
   assign sda_oe       = r_ff.oe;
   assign xif.wu_data  = r_ff.wu_buf;
   assign xif.wu_tgl   = r_ff.req_tgl;
   assign xif.snap_ack = r_ff.ack_tgl;

   // timer core on the oscillator clock
   wct_core #(
      .ONE_SHOT  (ONE_SHOT),
      .PUSH_PULL (PUSH_PULL),
      .OSC_HZ    (OSC_HZ),
      .PULSE_CYC (PULSE_CYC)
   ) u_core (
      .clk_osc      (clk_osc),
      .rstn         (rstn),
      .hold_reset_n (hold_reset_n),
      .xif          (xif.core),
      .wake_irq_o   (wake_irq_o),
      .wake_irq_oe  (wake_irq_oe)
   );
endmodule

/* rtl/wct_cfg.svh */
// wct_cfg.svh: constants of the wake-up compare timer (offsets, widths, reset values, counts)
// assumes: included by the package only, by its bare name
`ifndef WCT_CFG_SVH
`define WCT_CFG_SVH
`define WCT_CNT_W      24
`define WCT_CNT_MAX    24'hFFFFFF
`define WCT_CNT_RST    24'h000000
`define WCT_SLV_ADDR   7'h32
`define WCT_RD_FILL    8'hFF
`define WCT_PTR_RST    1'b1
`define WCT_PTR_BIT    7
`define WCT_WU_BYTES   3'h3
`define WCT_PRESC_W    16
`define WCT_OSC_HZ     32768
`define WCT_PULSE_CYC  32
`define WCT_PULSE_W    8
`endif

/* rtl/wct_pkg.sv */
// wct_pkg: state types of the wake-up compare timer
// assumes: wct_cfg.svh on the include path
package wct_pkg;
`include "wct_cfg.svh"
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK, I_RNXT} wct_i2c_st_t;
   typedef enum logic [1:0] {C_IDLE, C_RUN, C_HOLD, C_SAT} wct_core_st_t;
   // serial side state, clk_sys domain
   typedef struct packed {
      logic                  scl_s1, scl_s2, scl_q;
      logic                  sda_s1, sda_s2, sda_q;
      logic                  hr_s1, hr_s2;
      logic                  snap_s1, snap_s2, ack_tgl;
      wct_i2c_st_t           st;
      logic [2:0]            bitcnt;
      logic [7:0]            shreg;
      logic                  rw;
      logic [2:0]            bidx;
      logic                  ptr;
      logic [`WCT_CNT_W-1:0] wu_buf, rd_buf, cnt_cp, wu_cp;
      logic                  oe;
      logic                  req_tgl;
   } wct_i2c_t;
   // timer side state, oscillator domain
   typedef struct packed {
      logic                   rst_s1, rst_s2;
      logic                   hr_s1, hr_s2, hr_q;
      logic                   req_s1, req_s2, req_q;
      logic                   ack_s1, ack_s2;
      wct_core_st_t           st;
      logic [`WCT_PRESC_W-1:0] presc;
      logic [`WCT_CNT_W-1:0]  cnt, wu, cnt_snap, wu_snap;
      logic                   armed;
      logic                   hold;
      logic [`WCT_PULSE_W-1:0] pulse_cnt;
      logic                   snap_tgl;
   } wct_core_t;
endpackage

/* rtl/wct_core_if.sv */
// wct_core_if: crossing signals between serial side (clk_sys) and timer core (clk_osc)
// assumes: every toggle is synchronised by the receiving side; data is held while its toggle is pending
`timescale 1ns/1ns
interface wct_core_if;
   logic [23:0] wu_data;
   logic        wu_tgl;
   logic        snap_ack;
   logic        snap_tgl;
   logic [23:0] cnt_snap;
   logic [23:0] wu_snap;
   modport ser  (output wu_data, output wu_tgl, output snap_ack,
                 input snap_tgl, input cnt_snap, input wu_snap);
   modport core (input wu_data, input wu_tgl, input snap_ack,
                 output snap_tgl, output cnt_snap, output wu_snap);
endinterface

/* rtl/wct_core.sv */
// wct_core: seconds counter, wake-up compare and interrupt output, on the oscillator clock
// assumes: clk_osc free running; rstn and hold_reset_n are asynchronous to it and synchronised here
`timescale 1ns/1ns
module wct_core
   import wct_pkg::*;
#(
   parameter bit ONE_SHOT  = 1'b0,
   parameter bit PUSH_PULL = 1'b0,
   parameter int OSC_HZ    = `WCT_OSC_HZ,
   parameter int PULSE_CYC = `WCT_PULSE_CYC
)(
   // clock and reset
   input  wire logic clk_osc,
   input  wire logic rstn,
   // pin and crossing
   input  wire logic hold_reset_n,
   wct_core_if.core  xif,
   // interrupt pin
   output logic      wake_irq_o,
   output logic      wake_irq_oe
);
   localparam logic [`WCT_PRESC_W-1:0] PRESC_END = `WCT_PRESC_W'(OSC_HZ - 1);
   localparam logic [`WCT_PULSE_W-1:0] PULSE_LEN = `WCT_PULSE_W'(PULSE_CYC);

   wct_core_t r_ff;
   wct_core_t nxt_r;
   logic      act;
   logic      tick;
   logic      rise;
   logic      wr;

   // next state of the whole core
   always_comb
   begin
      nxt_r        = r_ff;
      nxt_r.rst_s1 = rstn;
      nxt_r.rst_s2 = r_ff.rst_s1;
      nxt_r.hr_s1  = hold_reset_n;
      nxt_r.hr_s2  = r_ff.hr_s1;
      nxt_r.hr_q   = r_ff.hr_s2;
      nxt_r.req_s1 = xif.wu_tgl;
      nxt_r.req_s2 = r_ff.req_s1;
      nxt_r.req_q  = r_ff.req_s2;
      nxt_r.ack_s1 = xif.snap_ack;
      nxt_r.ack_s2 = r_ff.ack_s1;
      rise = r_ff.hr_s2 & ~r_ff.hr_q;
      wr   = r_ff.req_s2 ^ r_ff.req_q;
      tick = (r_ff.presc == PRESC_END);
      if (r_ff.pulse_cnt != '0)
         nxt_r.pulse_cnt = r_ff.pulse_cnt - 1'b1;
      // once-per-second counting
      if (r_ff.st == C_RUN)
      begin
         nxt_r.presc = tick ? '0 : r_ff.presc + 1'b1;
         if (tick)
         begin
            if (r_ff.armed && (r_ff.cnt + 1'b1 == r_ff.wu))
            begin
               if (ONE_SHOT)
               begin
                  nxt_r.cnt       = `WCT_CNT_RST;
                  nxt_r.pulse_cnt = PULSE_LEN;
               end
               else
               begin
                  nxt_r.cnt  = r_ff.cnt + 1'b1;
                  nxt_r.st   = C_HOLD;
                  nxt_r.hold = 1'b1;
               end
            end
            else if (r_ff.cnt == `WCT_CNT_MAX)
               nxt_r.st = C_SAT;
            else
               nxt_r.cnt = r_ff.cnt + 1'b1;
         end
      end
      // a new wake-up time restarts a running or saturated count
      if (wr)
      begin
         nxt_r.wu    = xif.wu_data;
         nxt_r.armed = 1'b1;
         if (r_ff.st == C_RUN || r_ff.st == C_SAT)
         begin
            nxt_r.cnt   = `WCT_CNT_RST;
            nxt_r.presc = '0;
            nxt_r.st    = C_RUN;
         end
      end
      // pin held low: clear count; one-shot before match also forgets the wake-up time
      if (!r_ff.hr_s2)
      begin
         nxt_r.cnt   = `WCT_CNT_RST;
         nxt_r.presc = '0;
         nxt_r.st    = C_IDLE;
         if (ONE_SHOT && r_ff.st == C_RUN)
         begin
            nxt_r.wu    = `WCT_CNT_RST;
            nxt_r.armed = 1'b0;
         end
      end
      else if (rise)
      begin
         nxt_r.st    = C_RUN;
         nxt_r.hold  = 1'b0;
         nxt_r.cnt   = `WCT_CNT_RST;
         nxt_r.presc = '0;
      end
      // snapshot to the serial side, renewed once the previous one is taken
      if (r_ff.ack_s2 == r_ff.snap_tgl)
      begin
         nxt_r.cnt_snap = r_ff.cnt;
         nxt_r.wu_snap  = r_ff.wu;
         nxt_r.snap_tgl = ~r_ff.snap_tgl;
      end
      // synchronous reset keeps only the synchronisers and req_q running
      if (!r_ff.rst_s2)
      begin
         nxt_r        = '0;
         nxt_r.rst_s1 = rstn;
         nxt_r.rst_s2 = r_ff.rst_s1;
         nxt_r.hr_s1  = hold_reset_n;
         nxt_r.hr_s2  = r_ff.hr_s1;
         nxt_r.ack_s1 = xif.snap_ack;
         nxt_r.ack_s2 = r_ff.ack_s1;
         nxt_r.req_s1 = xif.wu_tgl;
         nxt_r.req_s2 = r_ff.req_s1;
         nxt_r.req_q  = r_ff.req_s2;
      end
   end

   always_ff @(posedge clk_osc)
   begin
      r_ff <= nxt_r;
   end

   // pin polarity follows the output variant
   assign act          = (r_ff.pulse_cnt != '0) | r_ff.hold;
   assign wake_irq_o   = PUSH_PULL ? act : 1'b0;
   assign wake_irq_oe  = PUSH_PULL ? 1'b1 : act;
   assign xif.snap_tgl = r_ff.snap_tgl;
   assign xif.cnt_snap = r_ff.cnt_snap;
   assign xif.wu_snap  = r_ff.wu_snap;
endmodule

/* tb/wct_top_chk.sv */
// wct_top_chk: port-level assertions on the wake-up compare timer
// assumes: bound to wct_top and sees only its pins
`timescale 1ns/1ns
module wct_top_chk
   import wct_pkg::*;
#(
   parameter bit ONE_SHOT  = 1'b0,
   parameter bit PUSH_PULL = 1'b0,
   parameter int OSC_HZ    = 8,
   parameter int PULSE_CYC = 4
)(
   // clocks and reset
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clk_osc,
   // serial pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // hold and interrupt pins
   input wire logic hold_reset_n,
   input wire logic wake_irq_o,
   input wire logic wake_irq_oe
);
   logic       act;
   logic [7:0] plen_ff;
   // active level of the interrupt in either output form
   assign act = PUSH_PULL ? wake_irq_o : wake_irq_oe;
   // osc cycles of the current active stretch; wraps in handshake, only used for pulses
   always_ff @(posedge clk_osc)
   begin
      plen_ff <= act ? plen_ff + 8'h01 : 8'h00;
   end
   sda_od_a: assert property (@(posedge clk_sys) sda_o == 1'b0)
      else $error("sda driven high");
   sda_rst_a: assert property (@(posedge clk_sys) !rstn |=> !sda_oe)
      else $error("sda pulled during reset");
   sda_chg_a: assert property (@(posedge clk_sys) disable iff (!rstn) $changed(sda_oe) |-> !scl_i)
      else $error("sda moved while scl high");
   sda_ack_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(sda_oe) |-> $past(scl_i, 2) || $past(scl_i, 3) || $past(scl_i, 4))
      else $error("sda pulled away from an scl fall");
   irq_od_a: assert property (@(posedge clk_osc) PUSH_PULL || !wake_irq_o)
      else $error("open drain pin driven high");
   irq_pp_a: assert property (@(posedge clk_osc) !PUSH_PULL || wake_irq_oe)
      else $error("push pull pin not driven");
   irq_rst_a: assert property (@(posedge clk_osc) !rstn [*3] |=> !act)
      else $error("interrupt active in reset");
   pulse_len_a: assert property (@(posedge clk_osc) disable iff (!rstn)
      ONE_SHOT && $fell(act) |-> plen_ff == PULSE_CYC)
      else $error("pulse length wrong");
   pulse_max_a: assert property (@(posedge clk_osc) disable iff (!rstn) ONE_SHOT |-> plen_ff <= PULSE_CYC)
      else $error("pulse too long");
   hs_hold_a: assert property (@(posedge clk_osc) disable iff (!rstn)
      !ONE_SHOT && act && !hold_reset_n |=> act)
      else $error("level released while hold low");
   irq_start_a: assert property (@(posedge clk_osc) disable iff (!rstn)
      $rose(act) |-> $past(hold_reset_n, 4))
      else $error("interrupt began while held");
endmodule
bind wct_top wct_top_chk #(.ONE_SHOT(ONE_SHOT), .PUSH_PULL(PUSH_PULL), .OSC_HZ(OSC_HZ), .PULSE_CYC(PULSE_CYC))
   i_wct_top_chk (.clk_sys, .rstn, .clk_osc, .scl_i, .sda_i, .sda_o, .sda_oe, .hold_reset_n, .wake_irq_o,
                  .wake_irq_oe);

/* tb/wct_host.sv */
// wct_host: behavioural host, two-wire master and hold pin driver
// assumes: sda_line is the resolved wire with a pull-up; clk_sys paces the bit timing
`timescale 1ns/1ns
module wct_host (
   // timing reference
   input  wire logic clk_sys,
   // bus wires, scl released high, sda_pull high pulls the wire low
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_pull,
   // hold pin
   output logic      hold_n
);
   localparam logic [6:0] ADDR = 7'h32;
   initial
   begin
      scl      = 1'b1;
      sda_pull = 1'b0;
      hold_n   = 1'b1;
   end
   // n sys cycles, then step off the edge
   task automatic hc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic set_hold(input logic v);
      hc(1);
      hold_n = v;
   endtask
   // start or repeated start: sda falls while scl high
   task automatic go();
      sda_pull = 1'b0;
      hc(5);
      scl = 1'b1;
      hc(5);
      sda_pull = 1'b1;
      hc(5);
      scl = 1'b0;
      hc(2);
   endtask
   // stop, which also resets the device pointer
   task automatic halt();
      sda_pull = 1'b1;
      hc(5);
      scl = 1'b1;
      hc(5);
      sda_pull = 1'b0;
      hc(5);
   endtask
   // data only moves with scl low, so no false start or stop
   task automatic bit1(input logic b, output logic r);
      sda_pull = !b;
      hc(5);
      scl = 1'b1;
      hc(3);
      r = sda_line;
      hc(3);
      scl = 1'b0;
      hc(2);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit1(b[i], r);
      bit1(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit1(1'b1, b[i]);
      bit1(last, r);
   endtask
   // wake-up write: address, pointer byte with test bit, three bytes msb first
   task automatic wr_wu(input logic [23:0] w, output logic ok);
      logic [4:0] a;
      go();
      wbyte({ADDR, 1'b0}, a[0]);
      wbyte(8'h81, a[1]);
      for (int i = 0; i < 3; i++)
         wbyte(w[23-8*i -: 8], a[2+i]);
      halt();
      ok = &a;
   endtask
   // read: wake-up register through dummy write and restart, else the count
   task automatic rd(input logic wu, output logic [23:0] v, output logic [7:0] x, output logic ok);
      logic [2:0] a;
      a = 3'b111;
      go();
      if (wu)
      begin
         wbyte({ADDR, 1'b0}, a[0]);
         wbyte(8'h01, a[1]);
         go();
      end
      wbyte({ADDR, 1'b1}, a[2]);
      rbyte(1'b0, v[23:16]);
      rbyte(1'b0, v[15:8]);
      rbyte(1'b0, v[7:0]);
      rbyte(1'b1, x);
      halt();
      ok = &a;
   endtask
endmodule

/* tb/wct_top_tb.sv */
// wct_top_tb: self-checking bench, one-shot loop build with open-drain pins,
// and a handshake build with push-pull pins listening to the same host
// assumes: wct_host as the far side; one timer second shortened to OSC osc cycles
`timescale 1ns/1ns
module wct_top_tb;
   import wct_pkg::*;
   localparam int OSC = 8;
   localparam int SEC = OSC * 30 / 8; // sys cycles per timer second
   logic clk_sys = 1'b0;
   logic clk_osc = 1'b0;
   logic rstn    = 1'b0;
   logic scl, sda_pull, sda_i, hold_n, sda_o, sda_oe, irq_o, irq_oe;
   logic sda2_i, sda2_o, sda2_oe, irq2_o, irq2_oe;
   int   fails   = 0;
   int   n_tests = 0;
   int   cyc     = 0;
   // clocks of unrelated phase
   always #4 clk_sys = !clk_sys;
   always #15 clk_osc = !clk_osc;
   always @(posedge clk_sys) cyc <= cyc + 1;
   // wired-and bus with pull-up
   assign sda_i = !(sda_oe | sda_pull);
   wct_top #(.ONE_SHOT(1'b1), .PUSH_PULL(1'b0), .OSC_HZ(OSC), .PULSE_CYC(4)) i_wct_top (
      .clk_sys(clk_sys), .rstn(rstn), .clk_osc(clk_osc), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o),
      .sda_oe(sda_oe), .hold_reset_n(hold_n), .wake_irq_o(irq_o), .wake_irq_oe(irq_oe));
   wct_host i_wct_host (.clk_sys(clk_sys), .sda_line(sda_i), .scl(scl), .sda_pull(sda_pull), .hold_n(hold_n));
   // handshake build on its own data wire; it sees every host write, the host reads only the first
   assign sda2_i = !(sda2_oe | sda_pull);
   wct_top #(.ONE_SHOT(1'b0), .PUSH_PULL(1'b1), .OSC_HZ(OSC), .PULSE_CYC(4)) i_wct_top_hs (
      .clk_sys(clk_sys), .rstn(rstn), .clk_osc(clk_osc), .scl_i(scl), .sda_i(sda2_i), .sda_o(sda2_o),
      .sda_oe(sda2_oe), .hold_reset_n(hold_n), .wake_irq_o(irq2_o), .wake_irq_oe(irq2_oe));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // bounded wait for an interrupt level; a required level that never comes ends the run
   task automatic wait_irq(input logic v, input int n, input bit must, output int k);
      k = 0;
      while (irq_oe !== v && k < n)
      begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      if (must && k >= n)
      begin
         fails++;
         $display("ERROR irq_oe expected %b seen %b", v, irq_oe);
         stop_test();
      end
   endtask
   // reset levels, then the count read twice across a known gap
   task automatic t_count();
      logic [23:0] v1, v2;
      logic [7:0]  x;
      logic        ok;
      int          c1, e;
      chk("sda_oe", 1'b0, sda_oe);
      chk("irq_oe", 1'b0, irq_oe);
      chk("irq_o", 1'b0, irq_o);
      chk("hs irq_o", 1'b0, irq2_o);
      chk("hs irq_oe", 1'b1, irq2_oe);
      c1 = cyc;
      i_wct_host.rd(1'b0, v1, x, ok);
      chk("read ack", 1'b1, ok);
      chk("fill byte", 8'hFF, x);
      chk("count from zero", 1'b1, v1 < 24'h00000A);
      repeat (10 * SEC) @(posedge clk_sys);
      e = (cyc - c1) / SEC;
      i_wct_host.rd(1'b0, v2, x, ok);
      chk("count step", 1'b1, (v2 - v1 + 2 >= e) && (v2 - v1 <= e + 2));
   endtask
   task automatic t_nak();
      logic a;
      i_wct_host.go();
      i_wct_host.wbyte(8'h66, a);
      i_wct_host.halt();
      chk("foreign address ack", 1'b0, a);
   endtask
   // write 40 s, read it back, then the pulse repeats every 40 s
   task automatic t_loop();
      logic [23:0] v;
      logic [7:0]  x;
      logic        ok;
      int          k, c;
      i_wct_host.wr_wu(24'h000028, ok);
      chk("write ack", 1'b1, ok);
      i_wct_host.rd(1'b1, v, x, ok);
      chk("wake-up readback", 24'h000028, v);
      wait_irq(1'b1, 45 * SEC, 1'b1, k);
      c = cyc;
      wait_irq(1'b0, 2 * SEC, 1'b1, k);
      wait_irq(1'b1, 45 * SEC, 1'b1, k);
      chk("loop period", 1'b1, (cyc - c > 38 * SEC) && (cyc - c < 42 * SEC));
      chk("hs level", 1'b1, irq2_o);
   endtask
   // rewrite mid-period: the old match time must pass silently
   task automatic t_rewrite();
      logic ok;
      int   k;
      wait_irq(1'b0, 2 * SEC, 1'b1, k);
      repeat (5 * SEC) @(posedge clk_sys);
      i_wct_host.wr_wu(24'h000028, ok);
      wait_irq(1'b1, 30 * SEC, 1'b0, k);
      chk("irq before restart", 1'b0, irq_oe);
      wait_irq(1'b1, 15 * SEC, 1'b1, k);
      chk("hs level after store", 1'b1, irq2_o);
   endtask
   // hold low before a match clears count and wake-up value; a write resumes
   task automatic t_hold();
      logic [23:0] v;
      logic [7:0]  x;
      logic        ok;
      int          k;
      wait_irq(1'b0, 2 * SEC, 1'b1, k);
      repeat (15 * SEC) @(posedge clk_sys);
      i_wct_host.set_hold(1'b0);
      repeat (SEC) @(posedge clk_sys);
      chk("hs level while held", 1'b1, irq2_o);
      i_wct_host.set_hold(1'b1);
      i_wct_host.rd(1'b0, v, x, ok);
      chk("count cleared", 1'b1, v < 24'h000008);
      chk("hs level released", 1'b0, irq2_o);
      i_wct_host.rd(1'b1, v, x, ok);
      chk("wake-up cleared", 24'h000000, v);
      wait_irq(1'b1, 50 * SEC, 1'b0, k);
      chk("irq without write", 1'b0, irq_oe);
      chk("hs match kept", 1'b1, irq2_o);
      i_wct_host.wr_wu(24'h000014, ok);
      wait_irq(1'b1, 25 * SEC, 1'b1, k);
   endtask
   // reset spans three osc cycles so the core sees it
   initial
   begin
      repeat (3) @(posedge clk_osc);
      @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      repeat (8) @(posedge clk_osc);
      t_count();
      $display("t_count done");
      t_nak();
      $display("t_nak done");
      t_loop();
      $display("t_loop done");
      t_rewrite();
      $display("t_rewrite done");
      t_hold();
      $display("t_hold done");
      stop_test();
   end
endmodule
